// file: hdl/event_timer_with_buzzer_out.v
// event timer: 8-bit up counter with preload, prescaler, three modes and
// a buzzer pair, reached over an ahb-lite slave
// assumes one clock, synchronous reset and a raw asynchronous input pin
`timescale 1ns/1ns
`default_nettype none
`include "event_timer_consts.vh"

module event_timer_with_buzzer_out (
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // ahb-lite slave
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // external event pin
   input wire timerPin,
   // shared port b pins, bit 0 and bit 1
   input wire portBIn0,
   input wire portBIn1,
   output reg portBOut0,
   output reg portBOut1,
   output reg portBOe0,
   output reg portBOe1,
   // system side
   input wire haltActive,
   output reg wakeUp,
   output wire irqRequest
);

   // -----------------------------------------------------------------
   // state machine states for pulse measurement
   // -----------------------------------------------------------------
   localparam [2:0] PW_IDLE = 3'b001;
   localparam [2:0] PW_WAIT = 3'b010;
   localparam [2:0] PW_MEAS = 3'b100;

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   reg [7:0] timerCount_r;
   reg [7:0] preload_r;
   reg [7:0] ctl_r;
   reg [7:0] irqCtl_r;
   reg [7:0] pinCfg_r;
   reg freqOut_r;
   reg [2:0] pwState_r;
   reg [2:0] pwState_nxt;
   reg pinSync1_r;
   reg pinSync2_r;
   reg pinSync3_r;
   reg pinLevel_r;
   reg dataPhase_r;
   reg dataWrite_r;
   reg [7:0] dataAddr_r;
   reg readBlock;
   reg countTick;
   reg [7:0] timerCount_nxt;
   reg runClear;
   wire prescTick;
   wire [1:0] mode;
   wire edgeFall;
   wire runOn;
   wire pinRise;
   wire pinFall;
   wire activeEdge;
   wire returnEdge;
   wire overflow;
   wire addrPhase;
   wire wrValue;
   wire wrControl;
   wire wrIrq;
   wire wrPin;
   wire [7:0] wrByte;
   wire buzzOn;

   // -----------------------------------------------------------------
   // functions
   // -----------------------------------------------------------------
   // register read decode; unmapped addresses read as zero
   function [7:0] regRead;
      input [7:0] addr;
      input [7:0] cnt;
      input [7:0] ctl;
      input [7:0] irq;
      input [7:0] pin;
      begin
         case (addr)
            `TIMER_VALUE_ADDR: regRead = cnt;
            `TIMER_CONTROL_ADDR: regRead = ctl & 8'hdf;
            `IRQ_CONTROL_ADDR: regRead = irq & 8'h21;
            `PIN_CONFIG_ADDR: regRead = pin & 8'h1f;
            default: regRead = 8'h00;
         endcase
      end
   endfunction

   // -----------------------------------------------------------------
   // control field decode
   // -----------------------------------------------------------------
   assign mode = ctl_r[`CTL_MODE_HI:`CTL_MODE_LO];
   assign edgeFall = ctl_r[`CTL_EDGE_BIT];
   assign runOn = ctl_r[`CTL_RUN_BIT];
   assign buzzOn = pinCfg_r[`PIN_BUZZ_BIT];

   // -----------------------------------------------------------------
   // prescaler
   // -----------------------------------------------------------------
   clock_divider u_div (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .divSel(ctl_r[`CTL_DIV_HI:`CTL_DIV_LO]),
      .tick(prescTick)
   );

   // -----------------------------------------------------------------
   // input pin synchroniser and edge detect
   // -----------------------------------------------------------------
   // three stages; a change counts once stages two and three agree
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         pinSync1_r <= 1'b0;
         pinSync2_r <= 1'b0;
         pinSync3_r <= 1'b0;
         pinLevel_r <= 1'b0;
      end else begin
         pinSync1_r <= timerPin;
         pinSync2_r <= pinSync1_r;
         pinSync3_r <= pinSync2_r;
         if (pinSync2_r == pinSync3_r)
            pinLevel_r <= pinSync3_r;
      end
   end

   assign pinRise = (pinSync2_r == pinSync3_r) && pinSync3_r && !pinLevel_r;
   assign pinFall = (pinSync2_r == pinSync3_r) && !pinSync3_r && pinLevel_r;
   assign activeEdge = edgeFall ? pinFall : pinRise;
   assign returnEdge = edgeFall ? pinRise : pinFall;

   // -----------------------------------------------------------------
   // ahb-lite slave
   // -----------------------------------------------------------------
   assign addrPhase = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wrByte = hwdata[7:0];
   assign wrValue = dataPhase_r && dataWrite_r && (dataAddr_r == `TIMER_VALUE_ADDR);
   assign wrControl = dataPhase_r && dataWrite_r && (dataAddr_r == `TIMER_CONTROL_ADDR);
   assign wrIrq = dataPhase_r && dataWrite_r && (dataAddr_r == `IRQ_CONTROL_ADDR);
   assign wrPin = dataPhase_r && dataWrite_r && (dataAddr_r == `PIN_CONFIG_ADDR);

   // address phase capture and read data
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         dataPhase_r <= 1'b0;
         dataWrite_r <= 1'b0;
         dataAddr_r <= 8'h00;
         hrdata <= 32'h00000000;
      end else begin
         dataPhase_r <= addrPhase;
         dataWrite_r <= hwrite;
         dataAddr_r <= haddr;
         if (addrPhase && !hwrite)
            hrdata <= {24'h000000, regRead(haddr, timerCount_r, ctl_r, irqCtl_r, pinCfg_r)};
      end
   end

   // counter clock is held off while the value is being read
   always @* begin
      readBlock = addrPhase && !hwrite && (haddr == `TIMER_VALUE_ADDR);
   end

   // -----------------------------------------------------------------
   // pulse width state machine
   // -----------------------------------------------------------------
   always @* begin
      pwState_nxt = pwState_r;
      runClear = 1'b0;
      case (pwState_r)
         PW_IDLE: begin
            if (mode == `MODE_PULSE && runOn)
               pwState_nxt = PW_WAIT;
         end
         PW_WAIT: begin
            if (mode != `MODE_PULSE || !runOn)
               pwState_nxt = PW_IDLE;
            else if (activeEdge)
               pwState_nxt = PW_MEAS;
         end
         PW_MEAS: begin
            if (mode != `MODE_PULSE || !runOn) begin
               pwState_nxt = PW_IDLE;
            end else if (returnEdge) begin
               pwState_nxt = PW_IDLE;
               runClear = 1'b1;
            end
         end
         default: pwState_nxt = PW_IDLE;
      endcase
   end

   always @(posedge ref_clk) begin
      if (sys_rst)
         pwState_r <= PW_IDLE;
      else
         pwState_r <= pwState_nxt;
   end

   // -----------------------------------------------------------------
   // count source selection
   // -----------------------------------------------------------------
   always @* begin
      case (mode)
         `MODE_EVENT: countTick = runOn && activeEdge;
         `MODE_TIMER: countTick = runOn && prescTick;
         `MODE_PULSE: countTick = (pwState_r == PW_MEAS) && prescTick;
         default: countTick = 1'b0;
      endcase
      if (readBlock)
         countTick = 1'b0;
   end

   assign overflow = countTick && (timerCount_r == `COUNT_MAX);

   // -----------------------------------------------------------------
   // counter and preload
   // -----------------------------------------------------------------
   always @* begin
      timerCount_nxt = timerCount_r;
      if (overflow)
         timerCount_nxt = preload_r;
      else if (countTick)
         timerCount_nxt = timerCount_r + 8'h01;
      if (wrValue && !runOn)
         timerCount_nxt = wrByte;
   end

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         timerCount_r <= `VALUE_RESET;
         preload_r <= `VALUE_RESET;
      end else begin
         timerCount_r <= timerCount_nxt;
         if (wrValue)
            preload_r <= wrByte;
      end
   end

   // -----------------------------------------------------------------
   // control register
   // -----------------------------------------------------------------
   // run bit cleared by hardware only when a pulse measurement completes
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         ctl_r <= `CTL_RESET;
      end else if (wrControl) begin
         ctl_r <= wrByte & 8'hdf;
      end else if (runClear) begin
         ctl_r[`CTL_RUN_BIT] <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // interrupt control: flag and enable
   // -----------------------------------------------------------------
   // overflow set wins over a software clear in the same cycle
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         irqCtl_r <= `IRQCTL_RESET;
      end else begin
         if (wrIrq) begin
            irqCtl_r[`IRQ_ENABLE_BIT] <= wrByte[`IRQ_ENABLE_BIT];
            irqCtl_r[`IRQ_FLAG_BIT] <= wrByte[`IRQ_FLAG_BIT] | overflow;
         end else if (overflow) begin
            irqCtl_r[`IRQ_FLAG_BIT] <= 1'b1;
         end
      end
   end

   assign irqRequest = irqCtl_r[`IRQ_FLAG_BIT] && irqCtl_r[`IRQ_ENABLE_BIT];

   // -----------------------------------------------------------------
   // wake-up and frequency output
   // -----------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         wakeUp <= 1'b0;
         freqOut_r <= 1'b0;
      end else begin
         wakeUp <= overflow && haltActive;
         if (overflow)
            freqOut_r <= !freqOut_r;
      end
   end

   // -----------------------------------------------------------------
   // pin configuration register
   // -----------------------------------------------------------------
   // bits: latch0, latch1, dir0, dir1 (1 = input), buzzer option
   always @(posedge ref_clk) begin
      if (sys_rst)
         pinCfg_r <= `PINCFG_RESET;
      else if (wrPin)
         pinCfg_r <= wrByte & 8'h1f;
   end

   // -----------------------------------------------------------------
   // shared pin drive
   // -----------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         portBOut0 <= 1'b0;
         portBOut1 <= 1'b0;
         portBOe0 <= 1'b0;
         portBOe1 <= 1'b0;
      end else begin
         portBOe0 <= !pinCfg_r[`PIN_DIR0_BIT];
         portBOe1 <= !pinCfg_r[`PIN_DIR1_BIT];
         if (buzzOn) begin
            portBOut0 <= pinCfg_r[`PIN_LATCH0_BIT] && freqOut_r;
            portBOut1 <= pinCfg_r[`PIN_LATCH0_BIT] && !freqOut_r;
         end else begin
            portBOut0 <= pinCfg_r[`PIN_LATCH0_BIT];
            portBOut1 <= pinCfg_r[`PIN_LATCH1_BIT];
         end
      end
   end

endmodule // event_timer_with_buzzer_out

`default_nettype wire

// file: hdl/event_timer_consts.vh
// register offsets, field positions, reset values and counts for the event timer
// assumes inclusion by bare name from the timer design files
`ifndef EVENT_TIMER_CONSTS_VH
`define EVENT_TIMER_CONSTS_VH

// register indices; a register's bus byte address is four times its index
`define TIMER_VALUE_IDX 6'h0d
`define TIMER_CONTROL_IDX 6'h0e
`define IRQ_CONTROL_IDX 6'h04
`define PIN_CONFIG_IDX 6'h05

// byte addresses on the register bus, one aligned word each
`define TIMER_VALUE_ADDR {`TIMER_VALUE_IDX, 2'h0}
`define TIMER_CONTROL_ADDR {`TIMER_CONTROL_IDX, 2'h0}
`define IRQ_CONTROL_ADDR {`IRQ_CONTROL_IDX, 2'h0}
`define PIN_CONFIG_ADDR {`PIN_CONFIG_IDX, 2'h0}

// control register fields
`define CTL_DIV_LO 0
`define CTL_DIV_HI 2
`define CTL_EDGE_BIT 3
`define CTL_RUN_BIT 4
`define CTL_MODE_LO 6
`define CTL_MODE_HI 7

// mode codes
`define MODE_UNUSED 2'h0
`define MODE_EVENT 2'h1
`define MODE_TIMER 2'h2
`define MODE_PULSE 2'h3

// irq control register fields
`define IRQ_ENABLE_BIT 0
`define IRQ_FLAG_BIT 5

// pin configuration register fields
`define PIN_LATCH0_BIT 0
`define PIN_LATCH1_BIT 1
`define PIN_DIR0_BIT 2
`define PIN_DIR1_BIT 3
`define PIN_BUZZ_BIT 4

// reset values
`define CTL_RESET 8'h08
`define IRQCTL_RESET 8'h00
`define PINCFG_RESET 8'h0f
`define VALUE_RESET 8'h00

// counter span
`define COUNT_MAX 8'hff

`endif

// file: hdl/clock_divider.v
// prescaler: free divider of the core clock giving one-cycle ticks
// assumes a single clock domain and synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none

module clock_divider (
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // divider selection
   input wire [2:0] divSel,
   // one-cycle tick at the selected rate
   output reg tick
);

   reg [7:0] divCnt_r;
   wire [7:0] divCnt_nxt;
   wire [7:0] divMask;

   // mask of low bits that must all be one: 000 -> /2 ... 111 -> /256
   assign divMask = (8'h02 << divSel) - 8'h01;
   assign divCnt_nxt = divCnt_r + 8'h01;

   // counter and tick
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         divCnt_r <= 8'h00;
         tick <= 1'b0;
      end else begin
         divCnt_r <= divCnt_nxt;
         tick <= ((divCnt_r & divMask) == divMask);
      end
   end

endmodule // clock_divider

`default_nettype wire

// file: verif/pin_source.sv
// pulse source standing in for whatever drives the event pin
// assumes one clock; a request is a one-cycle go, busy while pulsing
`timescale 1ns/1ns
`default_nettype none
module pin_source (
   // clock
   input wire logic ref_clk,
   // pulse request
   input wire logic idleLevel,
   input wire logic [7:0] width,
   input wire logic [3:0] count,
   input wire logic go,
   // pin and status
   output logic timerPin,
   output logic busy
);
   // rest at idle level, or send count pulses of width cycles each
   initial begin
      timerPin = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge ref_clk);
         if (!go) begin
            timerPin <= idleLevel;
         end else begin
            busy <= 1'b1;
            repeat (count) begin
               timerPin <= !idleLevel;
               repeat (width) @(posedge ref_clk);
               timerPin <= idleLevel;
               repeat (width) @(posedge ref_clk);
            end
            busy <= 1'b0;
         end
      end
   end
endmodule // pin_source
`default_nettype wire

// file: verif/timer_sva.sv
// assertions on the event timer's bus and system ports
// assumes a bind to event_timer_with_buzzer_out, one clock domain
`timescale 1ns/1ns
`default_nettype none
module timer_sva (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // bus
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // pins and system side
   input wire logic portBOe0,
   input wire logic portBOe1,
   input wire logic haltActive,
   input wire logic wakeUp
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // read address phase taken at this edge
   logic rdTaken;
   assign rdTaken = hsel && hready && htrans[1] && !hwrite;

   property p_zero_wait; hreadyout && !hresp; endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("bus stall or error");
   property p_upper_zero; rdTaken |=> hrdata[31:8] == 24'h0; endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
   property p_bit5_zero; rdTaken && haddr == 8'h38 |=> !hrdata[5]; endproperty
   a_bit5_zero: assert property (p_bit5_zero) else $error("control bit 5 reads one");
   property p_unmapped;
      rdTaken && !(haddr inside {8'h34, 8'h38, 8'h10, 8'h14}) |=> hrdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_rd_stands; !rdTaken |=> $stable(hrdata); endproperty
   a_rd_stands: assert property (p_rd_stands) else $error("read data moved");
   property p_wake_halt; wakeUp |-> $past(haltActive); endproperty
   a_wake_halt: assert property (p_wake_halt) else $error("wake without halt");
   property p_wake_pulse; wakeUp |=> !wakeUp; endproperty
   a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than a cycle");
   property p_reset_idle;
      $fell(sys_rst) |-> !portBOe0 && !portBOe1 && hrdata == 32'h0;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("pins driven after reset");
endmodule // timer_sva

bind event_timer_with_buzzer_out timer_sva u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .portBOe0(portBOe0),
   .portBOe1(portBOe1), .haltActive(haltActive), .wakeUp(wakeUp));
`default_nettype wire

// file: verif/event_timer_with_buzzer_out_test.sv
// self-checking bench for the event timer over its ahb-lite port
// assumes pin_source and the design compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module event_timer_with_buzzer_out_test;
   logic ref_clk, sys_rst, hsel, hwrite, haltActive, go, pIdle, pBusy, rdPend, sawWake;
   logic hreadyout, hresp, timerPin, wakeUp, irqRequest;
   logic portBOut0, portBOut1, portBOe0, portBOe1;
   logic [1:0] htrans;
   logic [3:0] pCount;
   logic [7:0] haddr, pWidth, v, e8;
   logic [15:0] lfsr;
   logic [31:0] hwdata, hrdata;
   logic [7:0] expQ[$];
   int n_mismatch, checked;
   time t0;

   event_timer_with_buzzer_out u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .timerPin(timerPin), .portBIn0(1'b0), .portBIn1(1'b0), .portBOut0(portBOut0),
      .portBOut1(portBOut1), .portBOe0(portBOe0), .portBOe1(portBOe1),
      .haltActive(haltActive), .wakeUp(wakeUp), .irqRequest(irqRequest));
   pin_source u_src (.ref_clk(ref_clk), .idleLevel(pIdle), .width(pWidth), .count(pCount),
      .go(go), .timerPin(timerPin), .busy(pBusy));

   function automatic logic [15:0] lfsrStep(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic summarize();
      if (n_mismatch == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // one bus transfer: address phase, then data phase
   task automatic xfer(input logic [7:0] a, input logic wrt, input logic [7:0] d);
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wrt;
      @(posedge ref_clk); while (!hreadyout) @(posedge ref_clk);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h0, d};
      @(posedge ref_clk); while (!hreadyout) @(posedge ref_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(a, 1'b1, d);
   endtask
   task automatic rdv(input logic [7:0] a, output logic [7:0] d);
      xfer(a, 1'b0, 8'h00);
      d = hrdata[7:0];
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] junk;
      expQ.push_back(e);
      rdv(a, junk);
   endtask
   task automatic pulse(input logic [7:0] wd, input logic [3:0] c);
      pWidth <= wd; pCount <= c; go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      @(posedge ref_clk);
      while (pBusy) @(posedge ref_clk);
      repeat (8) @(posedge ref_clk);
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // read data taken at the data-phase edge, checked against the oldest note
   always @(posedge ref_clk) begin
      if (rdPend) begin
         if (expQ.size() > 0) begin
            e8 = expQ.pop_front();
            `CHK(hrdata[7:0], e8)
         end
      end
      rdPend <= hsel && hreadyout && htrans[1] && !hwrite;
      if (wakeUp) sawWake <= 1'b1;
   end

   initial begin
      repeat (30000) @(posedge ref_clk);
      n_mismatch++;
      summarize();
   end

   initial begin
      lfsr = 16'he4fc; sys_rst = 1'b1; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0;
      hwrite = 1'b0; hwdata = 32'h0; haltActive = 1'b0; go = 1'b0; pIdle = 1'b0;
      pWidth = 8'h06; pCount = 4'h5; rdPend = 1'b0; sawWake = 1'b0; n_mismatch = 0; checked = 0;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      rd(8'h38, 8'h08);
      rd(8'h10, 8'h00);
      rd(8'h14, 8'h0f);
      wr(8'h20, 8'h55);
      rd(8'h20, 8'h00);
      for (int m = 0; m < 4; m++) begin
         wr(8'h38, {m[1:0], 6'h2f});
         rd(8'h38, {m[1:0], 6'h0f});
      end
      lfsr = lfsrStep(lfsr);
      wr(8'h34, lfsr[7:0]);
      rd(8'h34, lfsr[7:0]);
      for (int e = 0; e < 2; e++) begin
         wr(8'h38, 8'h40);
         pIdle <= e[0];
         repeat (8) @(posedge ref_clk);
         wr(8'h34, 8'h00);
         wr(8'h38, {4'h5, e[0], 3'h0});
         pulse(8'h06, 4'h5);
         pIdle <= !e[0];
         repeat (8) @(posedge ref_clk);
         rd(8'h34, 8'h06);
      end
      wr(8'h10, 8'h01);
      wr(8'h38, 8'h87);
      wr(8'h34, 8'hfc);
      haltActive <= 1'b1;
      wr(8'h38, 8'h97);
      while (irqRequest !== 1'b1) @(posedge ref_clk);
      haltActive <= 1'b0;
      rd(8'h34, 8'hfc);
      rd(8'h10, 8'h21);
      rd(8'h38, 8'h97);
      `CHK(sawWake, 1'b1)
      wr(8'h34, 8'h10);
      rdv(8'h34, v);
      `CHK(v != 8'h10, 1'b1)
      wr(8'h10, 8'h20);
      repeat (2) @(posedge ref_clk);
      `CHK(irqRequest, 1'b0)
      wr(8'h10, 8'h00);
      rd(8'h10, 8'h00);
      for (int d = 0; d < 2; d++) begin
         lfsr = lfsrStep(lfsr);
         wr(8'h38, 8'h80);
         wr(8'h14, 8'h11);
         wr(8'h34, {4'hf, lfsr[3:0]});
         wr(8'h38, {5'h12, d[2:0]});
         @(portBOut0);
         t0 = $time;
         @(portBOut0);
         `CHK(int'(($time - t0) / 100), (256 - {4'hf, lfsr[3:0]}) << (d + 1))
         @(posedge ref_clk);
         `CHK({portBOe0, portBOe1, portBOut1}, {2'h3, !portBOut0})
      end
      wr(8'h14, 8'h10);
      repeat (2) @(posedge ref_clk);
      `CHK({portBOut0, portBOut1}, 2'h0)
      wr(8'h14, 8'h15);
      repeat (2) @(posedge ref_clk);
      `CHK(portBOe0, 1'b0)
      wr(8'h38, 8'hc0);
      pIdle <= 1'b1;
      repeat (8) @(posedge ref_clk);
      wr(8'h34, 8'h00);
      wr(8'h38, 8'hd0);
      repeat (30) @(posedge ref_clk);
      rd(8'h34, 8'h00);
      pIdle <= 1'b0;
      repeat (8) @(posedge ref_clk);
      pulse(8'h28, 4'h1);
      rd(8'h38, 8'hc0);
      rdv(8'h34, v);
      `CHK(v >= 8'h12 && v <= 8'h16, 1'b1)
      pulse(8'h28, 4'h1);
      rd(8'h34, v);
      summarize();
   end
endmodule // event_timer_with_buzzer_out_test
`default_nettype wire
